//--- hdl/power_ctrl_consts.svh
// Offsets, field positions, reset values and timing counts of the block
`ifndef POWER_CTRL_CONSTS_SVH
`define POWER_CTRL_CONSTS_SVH

// Register byte addresses on the register bus
`define SYS_CLK_CTRL_ADR 8'hd4
`define STOP_UNLOCK_ADR 8'he0
`define PWR_STATUS_ADR 8'he8

// Reset values
`define SYS_CLK_CTRL_RST 8'h00
`define STOP_UNLOCK_RST 8'h00

// Field positions of the clock control register
`define IRQ_WAKE_OFF_BIT 7
`define DIV_SEL_HI 4
`define DIV_SEL_LO 3

// Divider select codes
`define DIV_SEL_16 2'b00
`define DIV_SEL_8 2'b01
`define DIV_SEL_2 2'b10
`define DIV_SEL_1 2'b11

// Codes
`define STOP_UNLOCK_CODE 8'ha5
`define IDLE_OPCODE 8'h6f
`define STOP_OPCODE_DFLT 8'h7f
`define RESET_VECTOR 16'h0100
`define WDT_OFF_NIBBLE 4'ha

// Timing
`define CLK_PERIOD_NS 25
`define RESET_STAB_NS 1000000
`define RESET_STAB_CYC ((`RESET_STAB_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define FILTER_NS 200
`define FILTER_CYC ((`FILTER_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define STAB_UNIT_CYC 256

`endif

//--- hdl/power_ctrl_pkg.sv
// Types shared by the clock, reset and power-down controller
package power_ctrl_pkg;
  // Sequencer states
  typedef enum logic [2:0] {
    ST_RESET, ST_STAB, ST_RUN, ST_IDLE, ST_STOP, ST_WAKE
  } pwr_state_t;
  // Divider select field
  typedef logic [1:0] div_sel_t;
endpackage : power_ctrl_pkg

//--- hdl/clock_reset_powerdown_ctrl.sv
// Clock divider, reset sequencer and Idle/Stop control with register slave
//
// Design decision made here: the Wishbone register port.
`timescale 1ns/1ps
`include "power_ctrl_consts.svh"

// Behaviour
// - CPU clock divided by 1, 2, 8 or 16
// - Reset: wake enabled, oscillator on, divide-by-16
// - Clock control bit 7 gates Stop wake-up
// - STOP acts only with unlock code held
// - Reset clears unlock register away from code
// - Stop halts oscillator, CPU and peripherals
// - Stop exits only on reset or filtered interrupt
// - Oscillator input forced low while stopped
// - Pin reset in Stop: defaults, wait, vector
// - Opcode 6FH enters Idle mode
// - Idle gates CPU and most peripheral clocks
// - Port directions held throughout Idle mode
// - Reset leaving Idle restores slowest clock
// - Enabled interrupt leaves Idle, divider kept
// - After Idle interrupt, resume at next instruction
// - Reset pin synchronised before use
// - Reset: interrupts off, watchdog on, ports input
// - Vector 0100H fetched after stabilisation
// - Wake-up wait taken from basic timer control
// - Watchdog resets on overflow outside Stop unless nibble 1010B
module clock_reset_powerdown_ctrl #(
  parameter int unsigned RESET_STAB_CYC = `RESET_STAB_CYC,
  parameter int unsigned STAB_UNIT_CYC = `STAB_UNIT_CYC,
  parameter int unsigned FILTER_CYC = `FILTER_CYC,
  parameter logic [7:0] STOP_OPCODE = `STOP_OPCODE_DFLT,
  parameter int unsigned CNT_W = 20
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Register bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Pins
  input wire logic external_reset_low_i,
  input wire logic ext_irq_i,
  // CPU core and interrupt logic
  input wire logic op_valid_i,
  input wire logic [7:0] opcode_i,
  input wire logic irq_enabled_i,
  // Basic timer
  input wire logic [7:0] basic_timer_control_i,
  input wire logic bt_overflow_i,
  // Clock gating and oscillator
  output logic cpu_clk_en_o,
  output logic periph_clk_en_o,
  output logic keep_clk_en_o,
  output logic osc_run_o,
  output logic xin_force_low_o,
  // Reset effects
  output logic ctl_reset_o,
  output logic irq_disable_o,
  output logic wdt_enable_o,
  output logic port_input_o,
  output logic pullup_off_o,
  output logic port_dir_hold_o,
  // Fetch control
  output logic fetch_start_o,
  output logic [15:0] fetch_addr_o,
  output logic idle_wake_o
);

  // Parameter checks, refused at elaboration
  if (RESET_STAB_CYC < 1 || RESET_STAB_CYC >= (1 << CNT_W) ||
      STAB_UNIT_CYC < 1 || (STAB_UNIT_CYC << 6) >= (1 << CNT_W) ||
      FILTER_CYC < 1 || FILTER_CYC > 255) begin : g_bad_param
    $error("stabilisation or filter counts do not fit the counters");
  end

  // Divider terminal count for a select code
  function automatic logic [3:0] div_term(power_ctrl_pkg::div_sel_t sel);
    case (sel)
      `DIV_SEL_16: div_term = 4'hf;
      `DIV_SEL_8: div_term = 4'h7;
      `DIV_SEL_2: div_term = 4'h1;
      default: div_term = 4'h0;
    endcase
  endfunction : div_term

  // Wake-up wait from the basic timer interval field
  function automatic logic [CNT_W-1:0] stab_len(logic [1:0] sel);
    logic [CNT_W-1:0] unit;
    unit = CNT_W'(STAB_UNIT_CYC);
    stab_len = unit << {sel, 1'b0};
  endfunction : stab_len

  // Registers
  logic [7:0] clk_ctrl_ff; // Clock control register
  logic [7:0] stop_unlock_ff; // Stop unlock register
  logic [1:0] btc_sel_ff; // Interval latched when entering Stop
  power_ctrl_pkg::pwr_state_t state_ff; // Sequencer state
  power_ctrl_pkg::pwr_state_t nxt_state;
  logic [CNT_W-1:0] stab_cnt_ff; // Stabilisation countdown
  logic [CNT_W-1:0] nxt_stab_cnt;
  logic [3:0] div_cnt_ff; // CPU clock divider
  logic rst_pin_s1_ff; // Reset pin synchroniser
  logic rst_pin_s2_ff;
  logic irq_s1_ff; // Interrupt pin synchroniser
  logic irq_s2_ff;
  logic [7:0] filt_cnt_ff; // Noise filter count
  logic irq_filt_ff; // Filtered interrupt level
  logic wb_ack_ff;
  logic [31:0] wb_dat_ff;
  logic cpu_clk_en_ff;
  logic periph_clk_en_ff;
  logic keep_clk_en_ff;
  logic osc_run_ff;
  logic xin_low_ff;
  logic ctl_reset_ff;
  logic port_hold_ff;
  logic fetch_start_ff;
  logic idle_wake_ff;
  logic wdt_en_ff;

  // Decoding of the bus request
  wire bus_req = wb_cyc_i && wb_stb_i && !wb_ack_ff;
  wire wr_en = bus_req && wb_we_i && wb_sel_i[0];
  wire hit_clk = (wb_adr_i == `SYS_CLK_CTRL_ADR);
  wire hit_stop = (wb_adr_i == `STOP_UNLOCK_ADR);
  wire hit_stat = (wb_adr_i == `PWR_STATUS_ADR);
  wire pin_reset = !rst_pin_s2_ff;
  wire [1:0] div_sel = clk_ctrl_ff[`DIV_SEL_HI:`DIV_SEL_LO];
  wire irq_wake_ok = !clk_ctrl_ff[`IRQ_WAKE_OFF_BIT];
  wire unlocked = (stop_unlock_ff == `STOP_UNLOCK_CODE);
  wire is_stop_op = op_valid_i && (opcode_i == STOP_OPCODE);
  wire is_idle_op = op_valid_i && (opcode_i == `IDLE_OPCODE);
  wire wdt_off = (basic_timer_control_i[7:4] == `WDT_OFF_NIBBLE);
  wire wdt_fire = bt_overflow_i && !wdt_off;
  wire ctl_rst = rst_i || pin_reset ||
                 (wdt_fire && state_ff != power_ctrl_pkg::ST_STOP);
  wire div_tick = (div_cnt_ff == div_term(div_sel));
  wire stab_done = (stab_cnt_ff == '0);
  wire in_run = (state_ff == power_ctrl_pkg::ST_RUN);
  wire in_idle = (state_ff == power_ctrl_pkg::ST_IDLE);
  wire in_stop = (state_ff == power_ctrl_pkg::ST_STOP);
  wire in_stab = (state_ff == power_ctrl_pkg::ST_STAB);
  wire in_wake = (state_ff == power_ctrl_pkg::ST_WAKE);
  wire [7:0] stat_word = {4'h0, wdt_en_ff, in_stab | in_wake,
                          in_stop, in_idle};
  wire [7:0] rd_byte = hit_clk ? clk_ctrl_ff :
                       hit_stop ? stop_unlock_ff :
                       hit_stat ? stat_word : 8'h00;

  // Reset pin and interrupt pin synchronisers
  always_ff @(posedge clk_i) begin
    rst_pin_s1_ff <= external_reset_low_i;
    rst_pin_s2_ff <= rst_pin_s1_ff;
    irq_s1_ff <= ext_irq_i;
    irq_s2_ff <= irq_s1_ff;
  end

  // Noise filter: the level must hold FILTER_CYC cycles
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      filt_cnt_ff <= 8'h00;
      irq_filt_ff <= 1'b0;
    end else if (irq_s2_ff == irq_filt_ff) begin
      filt_cnt_ff <= 8'h00;
    end else if (filt_cnt_ff == 8'(FILTER_CYC - 1)) begin
      filt_cnt_ff <= 8'h00;
      irq_filt_ff <= irq_s2_ff;
    end else begin
      filt_cnt_ff <= filt_cnt_ff + 8'h01;
    end
  end

  // Bus slave: ack one cycle after the request, writes land with it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_ff <= 1'b0;
      wb_dat_ff <= 32'h0000_0000;
    end else begin
      wb_ack_ff <= bus_req;
      wb_dat_ff <= {24'h00_0000, rd_byte};
    end
  end

  // Control registers; every control reset restores defaults
  always_ff @(posedge clk_i) begin
    if (ctl_rst) begin
      clk_ctrl_ff <= `SYS_CLK_CTRL_RST;
      stop_unlock_ff <= `STOP_UNLOCK_RST;
    end else if (wr_en && hit_clk) begin
      clk_ctrl_ff <= wb_dat_i[7:0];
    end else if (wr_en && hit_stop) begin
      stop_unlock_ff <= wb_dat_i[7:0];
    end
  end

  // Interval captured at Stop entry sets the wake-up wait
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      btc_sel_ff <= 2'b00;
    end else if (in_run && is_stop_op && unlocked) begin
      btc_sel_ff <= basic_timer_control_i[3:2];
    end
  end

  // Sequencer next state
  always_comb begin
    nxt_state = state_ff;
    nxt_stab_cnt = stab_cnt_ff;
    case (state_ff)
      // Held in reset while the pin is low
      power_ctrl_pkg::ST_RESET: begin
        if (!pin_reset) begin
          nxt_state = power_ctrl_pkg::ST_STAB;
          nxt_stab_cnt = CNT_W'(RESET_STAB_CYC - 1);
        end
      end
      // Stabilisation before the vector fetch
      power_ctrl_pkg::ST_STAB: begin
        if (stab_done) begin
          nxt_state = power_ctrl_pkg::ST_RUN;
        end else begin
          nxt_stab_cnt = stab_cnt_ff - CNT_W'(1);
        end
      end
      // Normal execution
      power_ctrl_pkg::ST_RUN: begin
        if (is_stop_op && unlocked) begin
          nxt_state = power_ctrl_pkg::ST_STOP;
        end else if (is_idle_op) begin
          nxt_state = power_ctrl_pkg::ST_IDLE;
        end
      end
      // Idle: any enabled interrupt releases it
      power_ctrl_pkg::ST_IDLE: begin
        if (irq_enabled_i) begin
          nxt_state = power_ctrl_pkg::ST_RUN;
        end
      end
      // Stop: filtered interrupt when bit 7 is clear
      power_ctrl_pkg::ST_STOP: begin
        if (irq_filt_ff && irq_wake_ok) begin
          nxt_state = power_ctrl_pkg::ST_WAKE;
          nxt_stab_cnt = stab_len(btc_sel_ff) - CNT_W'(1);
        end
      end
      // Oscillator restart wait, then resume after STOP
      power_ctrl_pkg::ST_WAKE: begin
        if (stab_done) begin
          nxt_state = power_ctrl_pkg::ST_RUN;
        end else begin
          nxt_stab_cnt = stab_cnt_ff - CNT_W'(1);
        end
      end
      default: begin
        nxt_state = power_ctrl_pkg::ST_RESET;
      end
    endcase
    // Pin reset in any state, watchdog in Run, Idle and Wake
    if (pin_reset) begin
      nxt_state = power_ctrl_pkg::ST_RESET;
    end else if (wdt_fire && !in_stop && !in_stab &&
                 state_ff != power_ctrl_pkg::ST_RESET) begin
      nxt_state = power_ctrl_pkg::ST_STAB;
      nxt_stab_cnt = stab_len(basic_timer_control_i[3:2]) - CNT_W'(1);
    end
  end

  // Sequencer registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_ff <= power_ctrl_pkg::ST_RESET;
      stab_cnt_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      stab_cnt_ff <= nxt_stab_cnt;
    end
  end

  // CPU clock divider, counting on the selected ratio in Run only
  always_ff @(posedge clk_i) begin
    if (rst_i || !in_run || div_tick) begin
      div_cnt_ff <= 4'h0;
    end else begin
      div_cnt_ff <= div_cnt_ff + 4'h1;
    end
  end

  // Clock gating and oscillator outputs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cpu_clk_en_ff <= 1'b0;
      periph_clk_en_ff <= 1'b0;
      keep_clk_en_ff <= 1'b0;
      osc_run_ff <= 1'b1;
      xin_low_ff <= 1'b0;
    end else begin
      cpu_clk_en_ff <= in_run && div_tick;
      periph_clk_en_ff <= in_run;
      keep_clk_en_ff <= in_run || in_idle;
      osc_run_ff <= !in_stop;
      xin_low_ff <= in_stop;
    end
  end

  // Reset effects, port hold and fetch strobes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctl_reset_ff <= 1'b1;
      wdt_en_ff <= 1'b1;
      port_hold_ff <= 1'b0;
      fetch_start_ff <= 1'b0;
      idle_wake_ff <= 1'b0;
    end else begin
      ctl_reset_ff <= ctl_rst;
      wdt_en_ff <= ctl_rst ? 1'b1 : !wdt_off;
      port_hold_ff <= in_idle && !pin_reset;
      fetch_start_ff <= in_stab && stab_done && !pin_reset;
      idle_wake_ff <= in_idle && irq_enabled_i && !pin_reset;
    end
  end

  // Outputs
  assign wb_ack_o = wb_ack_ff;
  assign wb_dat_o = wb_dat_ff;
  assign cpu_clk_en_o = cpu_clk_en_ff;
  assign periph_clk_en_o = periph_clk_en_ff;
  assign keep_clk_en_o = keep_clk_en_ff;
  assign osc_run_o = osc_run_ff;
  assign xin_force_low_o = xin_low_ff;
  assign ctl_reset_o = ctl_reset_ff;
  assign irq_disable_o = ctl_reset_ff;
  assign port_input_o = ctl_reset_ff;
  assign pullup_off_o = ctl_reset_ff;
  assign wdt_enable_o = wdt_en_ff;
  assign port_dir_hold_o = port_hold_ff;
  assign fetch_start_o = fetch_start_ff;
  assign fetch_addr_o = `RESET_VECTOR;
  assign idle_wake_o = idle_wake_ff;

  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence run_div16_tick;
    in_run && div_sel == `DIV_SEL_16 && cpu_clk_en_o;
  endsequence

  sequence idle_released;
    in_idle && irq_enabled_i && !pin_reset && !wdt_fire;
  endsequence

  chk_div_sixteen: assert property (
    run_div16_tick ##1 (in_run && $stable(div_sel)) [*8] |-> !cpu_clk_en_o)
    else $error("divide-by-16 tick came too early");
  chk_reset_defaults: assert property (
    pin_reset |=> clk_ctrl_ff == 8'h00 && !unlocked)
    else $error("control defaults not restored by reset");
  chk_stop_locked: assert property (
    in_run && is_stop_op && !unlocked && !pin_reset && !wdt_fire
      |=> !in_stop)
    else $error("STOP acted without unlock code");
  chk_stop_halts: assert property (
    in_stop && $past(in_stop) |-> !osc_run_o && xin_force_low_o
      && !cpu_clk_en_o && !periph_clk_en_o)
    else $error("clocks not halted in Stop");
  chk_wake_gated: assert property (
    in_stop && !irq_wake_ok && !pin_reset |=> in_stop)
    else $error("Stop left with wake-up disabled");
  chk_idle_entry: assert property (
    in_run && is_idle_op && !is_stop_op && !pin_reset && !wdt_fire
      |=> in_idle ##1 !cpu_clk_en_o && keep_clk_en_o)
    else $error("Idle entry or clock gating wrong");
  chk_idle_release: assert property (
    idle_released |=> in_run && $stable(div_sel) && idle_wake_o)
    else $error("Idle release wrong");
  chk_watchdog_rst: assert property (
    wdt_fire && in_run && !pin_reset |=> ctl_reset_o ##1 ctl_reset_o == 1'b0)
    else $error("watchdog did not reset");
  chk_fetch_after: assert property (
    fetch_start_o |-> $past(in_stab && stab_done) && fetch_addr_o == 16'h0100)
    else $error("fetch before stabilisation");
  chk_pin_sync: assert property (
    $fell(rst_pin_s2_ff) |=> ctl_reset_o)
    else $error("reset pin not acted on after sync");

endmodule : clock_reset_powerdown_ctrl

//--- sim/cpu_side_model.sv
// CPU core and interrupt logic stand-in on the far side of the block
`timescale 1ns/1ps
module cpu_side_model #(
  parameter logic [7:0] STOP_OP = 8'h7f,
  parameter logic [7:0] NOP_OP = 8'h00
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Requests from the bench
  input wire logic exec_req_i,
  input wire logic [7:0] exec_op_i,
  input wire logic irq_req_i,
  // Block side
  input wire logic cpu_clk_en_i,
  output logic op_valid_o,
  output logic [7:0] opcode_o,
  output logic irq_enabled_o
);
  logic pend_ff; // Instruction waiting for a CPU clock
  logic [7:0] op_ff; // Instruction to execute
  logic [1:0] nop_left_ff; // No-operations still owed after a stop
  // One instruction per CPU clock; a stop is padded with no-operations
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pend_ff <= 1'b0;
      op_ff <= 8'h00;
      nop_left_ff <= 2'd0;
      op_valid_o <= 1'b0;
      opcode_o <= 8'h00;
      irq_enabled_o <= 1'b0;
    end else begin
      irq_enabled_o <= irq_req_i;
      op_valid_o <= 1'b0;
      opcode_o <= ~opcode_o; // Undriven bus keeps changing
      if (exec_req_i) begin
        pend_ff <= 1'b1;
        op_ff <= exec_op_i;
      end else if (cpu_clk_en_i && pend_ff) begin
        pend_ff <= 1'b0;
        op_valid_o <= 1'b1;
        opcode_o <= op_ff;
        if (op_ff == STOP_OP)
          nop_left_ff <= 2'd3;
      end else if (cpu_clk_en_i && nop_left_ff != 2'd0) begin
        nop_left_ff <= nop_left_ff - 2'd1;
        op_valid_o <= 1'b1;
        opcode_o <= NOP_OP;
      end
    end
  end
endmodule : cpu_side_model

//--- sim/tb_top.sv
// Self-checking bench for the clock, reset and power-down controller
`timescale 1ns/1ps
`include "power_ctrl_consts.svh"
module tb_top;
  // Design and model connections
  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0] wb_adr_i, opcode_i, basic_timer_control_i, exec_op;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  logic [3:0] wb_sel_i;
  logic external_reset_low_i, ext_irq_i, op_valid_i, irq_enabled_i;
  logic bt_overflow_i, cpu_clk_en_o, periph_clk_en_o, keep_clk_en_o;
  logic osc_run_o, xin_force_low_o, ctl_reset_o, irq_disable_o;
  logic wdt_enable_o, port_input_o, pullup_off_o, port_dir_hold_o;
  logic fetch_start_o, idle_wake_o, exec_req, irq_req;
  logic [15:0] fetch_addr_o;
  int error_cnt, tests_run, n;
  // Block with shortened stabilisation counts
  clock_reset_powerdown_ctrl #(.RESET_STAB_CYC(20), .STAB_UNIT_CYC(4)) dut (
    .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_i,
    .wb_sel_i, .wb_dat_o, .wb_ack_o, .external_reset_low_i, .ext_irq_i,
    .op_valid_i, .opcode_i, .irq_enabled_i, .basic_timer_control_i,
    .bt_overflow_i, .cpu_clk_en_o, .periph_clk_en_o, .keep_clk_en_o,
    .osc_run_o, .xin_force_low_o, .ctl_reset_o, .irq_disable_o,
    .wdt_enable_o, .port_input_o, .pullup_off_o, .port_dir_hold_o,
    .fetch_start_o, .fetch_addr_o, .idle_wake_o);
  // CPU side
  cpu_side_model #(.STOP_OP(`STOP_OPCODE_DFLT)) cpu (
    .clk_i, .rst_i, .exec_req_i(exec_req), .exec_op_i(exec_op),
    .irq_req_i(irq_req), .cpu_clk_en_i(cpu_clk_en_o),
    .op_valid_o(op_valid_i), .opcode_o(opcode_i),
    .irq_enabled_o(irq_enabled_i));
  // Compare and count
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic cyc_n(input int k);
    repeat (k) @(posedge clk_i);
  endtask : cyc_n
  // One classic bus cycle, held until ack
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int k;
    k = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= {24'h0, d};
    wb_sel_i <= 4'hf;
    do begin
      @(posedge clk_i);
      k++;
    end while (wb_ack_o !== 1'b1 && k < 50);
    rd = wb_dat_o;
    if (k >= 50)
      chk("bus ack", 1'b1, 1'b0);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    @(posedge clk_i);
  endtask : wb
  task automatic rchk(input string nm, input logic [7:0] a,
                      input logic [7:0] e);
    wb(1'b0, a, 8'h00);
    chk(nm, {24'h0, e}, rd);
  endtask : rchk
  // Ask the CPU to run one instruction
  task automatic exec(input logic [7:0] op);
    exec_req <= 1'b1;
    exec_op <= op;
    @(posedge clk_i);
    exec_req <= 1'b0;
    repeat (40) if (op_valid_i !== 1'b1) @(posedge clk_i);
    cyc_n(3);
  endtask : exec
  // Wait for the vector fetch after a reset
  task automatic boot;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (fetch_start_o !== 1'b1 && n < 200);
    chk("fetch start", 1'b1, fetch_start_o);
    chk("fetch address", `RESET_VECTOR, fetch_addr_o);
    chk("stabilisation wait", 1'b1, n >= 20);
    cyc_n(2);
  endtask : boot
  task automatic pin_reset;
    external_reset_low_i <= 1'b0;
    cyc_n(2);
    chk("reset sync", 1'b0, ctl_reset_o);
    cyc_n(20);
    chk("reset effects", 5'h1f, {ctl_reset_o, irq_disable_o, wdt_enable_o,
        port_input_o, pullup_off_o});
    external_reset_low_i <= 1'b1;
    boot;
  endtask : pin_reset
  task automatic t_regs;
    rchk("clock ctrl", `SYS_CLK_CTRL_ADR, `SYS_CLK_CTRL_RST);
    rchk("unlock", `STOP_UNLOCK_ADR, 8'h00);
    chk("osc on", 1'b1, osc_run_o);
    rchk("unmapped", 8'h40, 8'h00);
    wb(1'b1, `STOP_UNLOCK_ADR, 8'h5a);
    rchk("unlock rw", `STOP_UNLOCK_ADR, 8'h5a);
    exec(`STOP_OPCODE_DFLT);
    chk("locked stop", 1'b1, osc_run_o);
    wb(1'b1, `SYS_CLK_CTRL_ADR, 8'h98);
    rchk("clock ctrl rw", `SYS_CLK_CTRL_ADR, 8'h98);
  endtask : t_regs
  // Divider gap for every select code
  task automatic t_div;
    logic [7:0] code [4] = '{8'h00, 8'h08, 8'h10, 8'h18};
    int ratio [4] = '{16, 8, 2, 1};
    foreach (code[i]) begin
      wb(1'b1, `SYS_CLK_CTRL_ADR, code[i]);
      cyc_n(40);
      repeat (40) if (cpu_clk_en_o !== 1'b1) @(posedge clk_i);
      n = 0;
      do begin
        @(posedge clk_i);
        n++;
      end while (cpu_clk_en_o !== 1'b1 && n < 40);
      chk("cpu clock gap", ratio[i], n);
    end
  endtask : t_div
  // Stop, reject a glitch, wake by interrupt; returns cycles to run
  task automatic stop_wake(input logic [7:0] btc, output int c);
    basic_timer_control_i <= btc;
    wb(1'b1, `STOP_UNLOCK_ADR, `STOP_UNLOCK_CODE);
    exec(`STOP_OPCODE_DFLT);
    chk("stop outputs", 4'h4, {osc_run_o, xin_force_low_o, periph_clk_en_o,
        keep_clk_en_o});
    ext_irq_i <= 1'b1;
    cyc_n(4);
    ext_irq_i <= 1'b0;
    cyc_n(12);
    chk("glitch filtered", 1'b0, osc_run_o);
    ext_irq_i <= 1'b1;
    c = 0;
    do begin
      @(posedge clk_i);
      c++;
    end while (periph_clk_en_o !== 1'b1 && c < 300);
    ext_irq_i <= 1'b0;
    chk("stop woken", 1'b1, osc_run_o);
  endtask : stop_wake
  task automatic t_stop;
    int a, b;
    wb(1'b1, `SYS_CLK_CTRL_ADR, 8'h00);
    stop_wake(8'h00, a);
    stop_wake(8'h04, b);
    chk("wake wait growth", 12, b - a);
    wb(1'b1, `SYS_CLK_CTRL_ADR, 8'h80);
    wb(1'b1, `STOP_UNLOCK_ADR, `STOP_UNLOCK_CODE);
    exec(`STOP_OPCODE_DFLT);
    ext_irq_i <= 1'b1;
    cyc_n(60);
    chk("wake blocked", 1'b0, osc_run_o);
    rchk("status stop", `PWR_STATUS_ADR, 8'h0a);
    ext_irq_i <= 1'b0;
    pin_reset;
    rchk("clock ctrl", `SYS_CLK_CTRL_ADR, 8'h00);
    rchk("unlock", `STOP_UNLOCK_ADR, 8'h00);
  endtask : t_stop
  task automatic t_idle;
    wb(1'b1, `SYS_CLK_CTRL_ADR, 8'h10);
    exec(`IDLE_OPCODE);
    chk("idle gating", 3'h3, {periph_clk_en_o, keep_clk_en_o,
        port_dir_hold_o});
    n = 0;
    repeat (32) begin
      @(posedge clk_i);
      if (cpu_clk_en_o !== 1'b0)
        n++;
    end
    chk("cpu clock idle", 0, n);
    irq_req <= 1'b1;
    repeat (20) if (idle_wake_o !== 1'b1) @(posedge clk_i);
    chk("idle wake", 1'b1, idle_wake_o);
    irq_req <= 1'b0;
    cyc_n(3);
    chk("run again", 1'b1, periph_clk_en_o);
    rchk("divider kept", `SYS_CLK_CTRL_ADR, 8'h10);
    exec(`IDLE_OPCODE);
    cyc_n(50);
    chk("masked idle", 1'b1, port_dir_hold_o);
    wb(1'b1, `PWR_STATUS_ADR, 8'hff);
    rchk("status idle", `PWR_STATUS_ADR, 8'h09);
    pin_reset;
    rchk("slowest clock", `SYS_CLK_CTRL_ADR, 8'h00);
  endtask : t_idle
  task automatic ovf;
    bt_overflow_i <= 1'b1;
    @(posedge clk_i);
    bt_overflow_i <= 1'b0;
  endtask : ovf
  task automatic t_wdt;
    basic_timer_control_i <= {`WDT_OFF_NIBBLE, 4'h0};
    cyc_n(3);
    chk("watchdog off", 1'b0, wdt_enable_o);
    ovf;
    cyc_n(6);
    chk("no dog reset", 1'b0, ctl_reset_o);
    basic_timer_control_i <= 8'h00;
    cyc_n(3);
    chk("watchdog on", 1'b1, wdt_enable_o);
    ovf;
    repeat (10) if (ctl_reset_o !== 1'b1) @(posedge clk_i);
    chk("dog reset", 1'b1, ctl_reset_o);
    repeat (200) if (periph_clk_en_o !== 1'b1) @(posedge clk_i);
    chk("dog recovers", 1'b1, periph_clk_en_o);
  endtask : t_wdt
  task automatic fin(input string s);
    $display("test %s done, mismatches so far %0d", s, error_cnt);
  endtask : fin
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : end_of_test
  // 40 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  // Watchdog against a hang
  initial begin
    cyc_n(20000);
    error_cnt++;
    end_of_test;
  end
  // Main sequence
  initial begin
    {rst_i, external_reset_low_i} = 2'b11;
    {wb_cyc_i, wb_stb_i, wb_we_i, ext_irq_i} = 4'h0;
    {exec_req, irq_req, bt_overflow_i} = 3'h0;
    {wb_adr_i, exec_op, basic_timer_control_i} = 24'h0;
    wb_dat_i = 32'h0;
    wb_sel_i = 4'hf;
    cyc_n(10);
    rst_i <= 1'b0;
    boot;
    t_regs;
    fin("registers");
    t_div;
    fin("divider");
    t_stop;
    fin("stop");
    t_idle;
    fin("idle");
    t_wdt;
    fin("watchdog");
    end_of_test;
  end
endmodule : tb_top
